// ==== design/enc_count_pkg.sv ====
package enc_count_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_PER_S = 1000;
  localparam int BASE_CYCLES = CLK_HZ / MS_PER_S;
  localparam int SEC_PER_MIN = 60;
  localparam int PER_FRAC = 22;
  localparam int UPD_MS [4] = '{1, 10, 100, 1000};
  localparam int UPD_MUL [4] = '{1000, 100, 10, 1};
  localparam int UPD_Q22 [4] = '{4194, 41943, 419430, 4194304};
  localparam int NIN = 6;
  localparam int IN_N = 2;
  localparam int IN_DI = 3;

  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_CFG = 4'h1;
  localparam logic [3:0] A_HI = 4'h2;
  localparam logic [3:0] A_LO = 4'h3;
  localparam logic [3:0] A_START = 4'h4;
  localparam logic [3:0] A_CMP0 = 4'h5;
  localparam logic [3:0] A_CMP1 = 4'h6;
  localparam logic [3:0] A_HYST = 4'h7;
  localparam logic [3:0] A_CMPCFG = 4'h8;
  localparam logic [3:0] A_IPU = 4'h9;
  localparam logic [3:0] A_COUNT = 4'hA;
  localparam logic [3:0] A_CAPT = 4'hB;
  localparam logic [3:0] A_FREQ = 4'hC;
  localparam logic [3:0] A_PER = 4'hD;
  localparam logic [3:0] A_VEL = 4'hE;
  localparam logic [3:0] A_STAT = 4'hF;

  localparam logic [31:0] RST_HI = 32'h7FFF_FFFF;
  localparam logic [31:0] RST_LO = 32'h8000_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_IPU = 32'h0000_0001;

  typedef enum logic [1:0] {ENC_QUAD, ENC_PULSE_DIR, ENC_PULSE, ENC_UPDOWN} enc_t;
  typedef enum logic [2:0] {CAP_OFF, CAP_RISE, CAP_FALL, CAP_BOTH, CAP_N} cap_t;
  typedef enum logic [2:0] {SYN_OFF, SYN_RISE, SYN_FALL, SYN_N, SYN_N_LVL} syn_t;
  typedef enum logic [1:0] {CMP_OFF, CMP_GE, CMP_LE, CMP_EQ} cond_t;
  typedef enum logic [1:0] {MT_FREQ, MT_PER, MT_VEL} meas_t;

  typedef struct packed {
    logic [6:0] filt;
    logic tb_min;
    logic [1:0] upd;
    meas_t mtype;
    logic meas_mode;
    logic gate_load;
    logic [1:0] sync_di;
    syn_t sync_sel;
    logic cap_reload;
    logic [1:0] cap_di;
    cap_t cap_sel;
    logic reload_opp;
    logic limit_stop;
    logic [1:0] hw_sel;
    logic hw_en;
    enc_t enc;
  } cfg_t;

  typedef struct packed {
    logic [23:0] pad;
    logic [3:0] ev_en;
    cond_t cond1;
    cond_t cond0;
  } cmpcfg_t;

  typedef struct packed {
    logic [31:0] counter;
    logic [31:0] capture;
    logic [31:0] measured;
    logic [7:0] status;
  } feedback_t;
endpackage : enc_count_pkg

// ==== design/enc_count.sv ====
// Design decisions made here: the register offsets and the plain strobed port.
module enc_count
  import enc_count_pkg::*;
#(
  parameter int UPD_BASE = BASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  input wire logic i_enc_n,
  input wire logic i_process_input_0,
  input wire logic i_process_input_1,
  input wire logic i_process_input_2,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_compare_output_0,
  output logic o_compare_output_1,
  output logic o_hw_event,
  output logic [3:0] o_event_cause,
  output feedback_t o_feedback
);
  function automatic logic di_pick(logic [NIN-1:0] v, logic [1:0] s);
    return (s == 2'h2) ? v[IN_DI+2] : (s == 2'h1) ? v[IN_DI+1] : v[IN_DI];
  endfunction : di_pick

  function automatic logic [31:0] sgn(logic s, logic [31:0] m);
    return s ? 32'(-m) : m;
  endfunction : sgn

  function automatic logic [31:0] to_float(logic s, logic [31:0] m, int adj);
    int p;
    logic [31:0] sh;
    p = 0;
    for (int i = 0; i < 32; i++) begin
      if (m[i]) p = i;
    end
    sh = m << (31 - p);
    if (m == 32'h0000_0000) return 32'h0000_0000;
    return {s, 8'(127 + p - adj), sh[30:8]};
  endfunction : to_float

  function automatic logic cmp_next(logic cur, cond_t c, logic [31:0] v,
                                    logic [31:0] r, logic [31:0] h);
    logic signed [32:0] d;
    logic signed [32:0] hh;
    d = $signed({v[31], v}) - $signed({r[31], r});
    hh = $signed({1'b0, h});
    case (c)
      CMP_GE: return cur ? !(d < -hh) : (d >= 0);
      CMP_LE: return cur ? !(d > hh) : (d <= 0);
      CMP_EQ: return cur ? !(d > hh || d < -hh) : (d == 0);
      default: return 1'b0;
    endcase
  endfunction : cmp_next

  logic [NIN-1:0] s1_r, s2_r, flt_r, prv_r;
  logic [6:0] fcnt_r [NIN];
  cfg_t cfg_r;
  cmpcfg_t ccfg_r;
  logic [1:0] ctrl_r;
  logic [31:0] hi_r, lo_r, start_r, cmp0_r, cmp1_r, hyst_r, ipu_r;
  logic [31:0] cnt_r, cnt_nxt, cap_r, rdata_r;
  logic auto_r, auto_nxt, gate_r, last_up_r;

  // input synchroniser and interference filter
  wire [NIN-1:0] raw_w = {i_process_input_2, i_process_input_1, i_process_input_0,
                          i_enc_n, i_enc_b, i_enc_a};
  always_ff @(posedge i_clk) begin
    s1_r <= raw_w;
    s2_r <= s1_r;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flt_r <= '0;
      prv_r <= '0;
      for (int i = 0; i < NIN; i++) fcnt_r[i] <= '0;
    end else begin
      prv_r <= flt_r;
      for (int i = 0; i < NIN; i++) begin
        if (s2_r[i] == flt_r[i]) fcnt_r[i] <= '0;
        else if (fcnt_r[i] >= cfg_r.filt) begin
          flt_r[i] <= s2_r[i];
          fcnt_r[i] <= '0;
        end else fcnt_r[i] <= fcnt_r[i] + 7'h01;
      end
    end
  end

  // signal evaluation per encoder type
  wire a = flt_r[0], b = flt_r[1], pa = prv_r[0], pb = prv_r[1];
  wire a_rise = a & !pa;
  wire b_rise = b & !pb;
  logic step_w, up_w;
  always_comb begin
    step_w = 1'b0;
    up_w = 1'b1;
    case (cfg_r.enc)
      ENC_QUAD: begin
        step_w = (a ^ pa) ^ (b ^ pb);
        up_w = (a ^ pa) ? (a ^ pb) : !(b ^ pa);
      end
      ENC_PULSE_DIR: begin
        step_w = a_rise;
        up_w = !b;
      end
      ENC_PULSE: begin
        step_w = a_rise;
        up_w = !ctrl_r[1];
      end
      default: begin
        step_w = a_rise ^ b_rise;
        up_w = a_rise;
      end
    endcase
  end

  // gate, capture and synchronisation triggers
  wire hw_ok = !cfg_r.hw_en | di_pick(flt_r, cfg_r.hw_sel);
  wire gate_open = ctrl_r[0] & hw_ok & !auto_r;
  wire gate_rise = gate_open & !gate_r;
  wire step_ok = step_w & gate_open;
  wire n_rise = flt_r[IN_N] & !prv_r[IN_N];
  wire cdi = di_pick(flt_r, cfg_r.cap_di);
  wire cdi_p = di_pick(prv_r, cfg_r.cap_di);
  wire sdi = di_pick(flt_r, cfg_r.sync_di);
  wire sdi_p = di_pick(prv_r, cfg_r.sync_di);
  wire cap_hit = (cfg_r.cap_sel == CAP_RISE) ? cdi & !cdi_p :
                 (cfg_r.cap_sel == CAP_FALL) ? !cdi & cdi_p :
                 (cfg_r.cap_sel == CAP_BOTH) ? cdi ^ cdi_p :
                 (cfg_r.cap_sel == CAP_N) ? n_rise : 1'b0;
  wire sync_hit = (cfg_r.sync_sel == SYN_RISE) ? sdi & !sdi_p :
                  (cfg_r.sync_sel == SYN_FALL) ? !sdi & sdi_p :
                  (cfg_r.sync_sel == SYN_N) ? n_rise :
                  (cfg_r.sync_sel == SYN_N_LVL) ? n_rise & sdi : 1'b0;
  wire [31:0] start_eff = ($signed(start_r) > $signed(hi_r)) ? hi_r :
                          ($signed(start_r) < $signed(lo_r)) ? lo_r : start_r;
  wire ovf = step_ok & up_w & (cnt_r == hi_r);
  wire unf = step_ok & !up_w & (cnt_r == lo_r);
  wire [31:0] ovf_val = cfg_r.reload_opp ? lo_r : start_eff;
  wire [31:0] unf_val = cfg_r.reload_opp ? hi_r : start_eff;
  wire cap_load = cap_hit & cfg_r.cap_reload;
  wire gate_ld = gate_rise & cfg_r.gate_load;
  wire any_load = sync_hit | cap_load | gate_ld;

  always_comb begin
    if (sync_hit | cap_load | gate_ld) cnt_nxt = start_eff;
    else if (ovf) cnt_nxt = ovf_val;
    else if (unf) cnt_nxt = unf_val;
    else if (step_ok) cnt_nxt = up_w ? cnt_r + 32'h0000_0001 : cnt_r - 32'h0000_0001;
    else cnt_nxt = cnt_r;
  end
  wire sw_open_wr = i_wr && (i_addr == A_CTRL) && i_wdata[0] && !ctrl_r[0];
  assign auto_nxt = ((ovf | unf) & cfg_r.limit_stop) ? 1'b1 :
                    sw_open_wr ? 1'b0 : auto_r;

  // register writes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r <= '0;
      cfg_r <= cfg_t'(RST_ZERO);
      ccfg_r <= cmpcfg_t'(RST_ZERO);
      hi_r <= RST_HI;
      lo_r <= RST_LO;
      start_r <= RST_ZERO;
      cmp0_r <= RST_ZERO;
      cmp1_r <= RST_ZERO;
      hyst_r <= RST_ZERO;
      ipu_r <= RST_IPU;
    end else if (i_wr) begin
      if (i_addr == A_CTRL) ctrl_r <= i_wdata[1:0];
      else if (i_addr == A_CFG) cfg_r <= cfg_t'(i_wdata);
      else if (i_addr == A_HI) hi_r <= i_wdata;
      else if (i_addr == A_LO) lo_r <= i_wdata;
      else if (i_addr == A_START) start_r <= i_wdata;
      else if (i_addr == A_CMP0) cmp0_r <= i_wdata;
      else if (i_addr == A_CMP1) cmp1_r <= i_wdata;
      else if (i_addr == A_HYST) hyst_r <= i_wdata;
      else if (i_addr == A_CMPCFG) ccfg_r <= cmpcfg_t'(i_wdata);
      else if (i_addr == A_IPU) ipu_r <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= RST_ZERO;
      cap_r <= RST_ZERO;
      auto_r <= 1'b0;
      gate_r <= 1'b0;
      last_up_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      auto_r <= auto_nxt;
      gate_r <= gate_open;
      if (cap_hit) cap_r <= cnt_r;
      if (step_ok) last_up_r <= up_w;
    end
  end

  // free running update timer
  logic [31:0] pre_r;
  logic [9:0] ms_r;
  logic signed [31:0] net_r;
  wire ms_tick = (pre_r == 32'(UPD_BASE - 1));
  wire iv_end = ms_tick && (ms_r == 10'(UPD_MS[cfg_r.upd] - 1));
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pre_r <= '0;
      ms_r <= '0;
      net_r <= '0;
    end else begin
      pre_r <= ms_tick ? '0 : pre_r + 32'h0000_0001;
      if (iv_end) ms_r <= '0;
      else if (ms_tick) ms_r <= ms_r + 10'h001;
      if (iv_end) net_r <= '0;
      else if (step_ok) net_r <= up_w ? net_r + 1 : net_r - 1;
    end
  end

  // measurement with serial divider
  typedef enum {M_IDLE, M_PER, M_VEL} mstate_t;
  mstate_t ms_st;
  logic nsg_r;
  logic [31:0] mag_r, dnum_r, dden_r, dquo_r;
  logic [32:0] drem_r;
  logic [4:0] dcnt_r;
  logic [31:0] freq_r, per_r, vel_r, freq_i, per_i, vel_i;
  wire [31:0] net_mag = net_r[31] ? 32'(-net_r) : 32'(net_r);
  wire [32:0] rem_sh = {drem_r[31:0], dnum_r[31]};
  wire dge = rem_sh >= {1'b0, dden_r};
  wire [31:0] quo_fin = {dquo_r[30:0], dge};
  wire [31:0] tb_mul = cfg_r.tb_min ? 32'(SEC_PER_MIN) : 32'h0000_0001;
  wire [31:0] f_mag = 32'(net_mag * 32'(UPD_MUL[cfg_r.upd]));
  wire [31:0] v_num = 32'(mag_r * 32'(UPD_MUL[cfg_r.upd]) * tb_mul);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ms_st <= M_IDLE;
      {nsg_r, mag_r, dnum_r, dden_r, dquo_r, drem_r, dcnt_r} <= '0;
      {freq_r, per_r, vel_r, freq_i, per_i, vel_i} <= '0;
    end else begin
      case (ms_st)
        M_IDLE: begin
          if (iv_end && gate_open) begin
            nsg_r <= net_r[31];
            mag_r <= net_mag;
            freq_r <= to_float(net_r[31], f_mag, 0);
            freq_i <= sgn(net_r[31], f_mag);
            dnum_r <= 32'(UPD_Q22[cfg_r.upd]);
            dden_r <= net_mag;
            {drem_r, dquo_r, dcnt_r} <= '0;
            ms_st <= M_PER;
          end
        end
        M_PER, M_VEL: begin
          drem_r <= dge ? rem_sh - {1'b0, dden_r} : rem_sh;
          dnum_r <= dnum_r << 1;
          dquo_r <= quo_fin;
          dcnt_r <= dcnt_r + 5'h01;
          if (dcnt_r == 5'h1F && ms_st == M_PER) begin
            per_r <= (mag_r == 0) ? '0 : to_float(nsg_r, quo_fin, PER_FRAC);
            per_i <= (mag_r == 0) ? '0 : sgn(nsg_r, quo_fin);
            dnum_r <= v_num;
            dden_r <= (ipu_r == 0) ? 32'h0000_0001 : ipu_r;
            {drem_r, dquo_r} <= '0;
            ms_st <= M_VEL;
          end else if (dcnt_r == 5'h1F) begin
            vel_r <= to_float(nsg_r, quo_fin, 0);
            vel_i <= sgn(nsg_r, quo_fin);
            ms_st <= M_IDLE;
          end
        end
        default: ms_st <= M_IDLE;
      endcase
    end
  end

  // comparison outputs and events
  wire [31:0] meas_i = (cfg_r.mtype == MT_PER) ? per_i :
                       (cfg_r.mtype == MT_VEL) ? vel_i : freq_i;
  wire [31:0] meas_f = (cfg_r.mtype == MT_PER) ? per_r :
                       (cfg_r.mtype == MT_VEL) ? vel_r : freq_r;
  wire [31:0] cmp_v = cfg_r.meas_mode ? meas_i : cnt_r;
  wire out0_nxt = cmp_next(o_compare_output_0, ccfg_r.cond0, cmp_v, cmp0_r, hyst_r);
  wire out1_nxt = cmp_next(o_compare_output_1, ccfg_r.cond1, cmp_v, cmp1_r, hyst_r);
  wire cmp_rise = (out0_nxt & !o_compare_output_0) | (out1_nxt & !o_compare_output_1);
  wire zero_x = (cnt_nxt == 0) && (cnt_r != 0);
  wire rev = step_ok && (up_w != last_up_r);
  wire [3:0] cause_w = {rev, zero_x, ovf | unf, cmp_rise} & ccfg_r.ev_en;
  wire [7:0] stat_w = {last_up_r, gate_open, o_compare_output_1, o_compare_output_0,
                       flt_r[IN_DI+2:IN_DI], auto_r};
  logic [31:0] rd_mux;
  always_comb begin
    if (i_addr == A_CTRL) rd_mux = {30'h0000_0000, ctrl_r};
    else if (i_addr == A_CFG) rd_mux = cfg_r;
    else if (i_addr == A_HI) rd_mux = hi_r;
    else if (i_addr == A_LO) rd_mux = lo_r;
    else if (i_addr == A_START) rd_mux = start_r;
    else if (i_addr == A_CMP0) rd_mux = cmp0_r;
    else if (i_addr == A_CMP1) rd_mux = cmp1_r;
    else if (i_addr == A_HYST) rd_mux = hyst_r;
    else if (i_addr == A_CMPCFG) rd_mux = ccfg_r;
    else if (i_addr == A_IPU) rd_mux = ipu_r;
    else if (i_addr == A_COUNT) rd_mux = cnt_r;
    else if (i_addr == A_CAPT) rd_mux = cap_r;
    else if (i_addr == A_FREQ) rd_mux = freq_r;
    else if (i_addr == A_PER) rd_mux = per_r;
    else if (i_addr == A_VEL) rd_mux = vel_r;
    else rd_mux = {24'h00_0000, stat_w};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_compare_output_0 <= 1'b0;
      o_compare_output_1 <= 1'b0;
      o_hw_event <= 1'b0;
      o_event_cause <= '0;
      o_feedback <= '0;
      rdata_r <= '0;
    end else begin
      o_compare_output_0 <= out0_nxt;
      o_compare_output_1 <= out1_nxt;
      o_hw_event <= |cause_w;
      o_event_cause <= cause_w;
      o_feedback <= '{cnt_r, cap_r, meas_f, stat_w};
      rdata_r <= i_rd ? rd_mux : '0;
    end
  end
  assign o_rdata = rdata_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  count_up_a: assert property (step_ok && up_w && cnt_r != hi_r && !any_load
    |=> cnt_r == $past(cnt_r) + 1) else $error("count step wrong");
  gate_hold_a: assert property (!gate_open && !sync_hit && !cap_load
    |=> $stable(cnt_r)) else $error("counted with gate closed");
  capture_a: assert property (cap_hit |=> cap_r == $past(cnt_r))
    else $error("capture value wrong");
  sync_load_a: assert property (sync_hit |=> cnt_r == $past(start_eff))
    else $error("sync did not load start");
  ovf_wrap_a: assert property (ovf && !any_load |=> cnt_r == $past(ovf_val))
    else $error("overflow reload wrong");
  auto_stop_a: assert property ((ovf | unf) && cfg_r.limit_stop
    |=> !gate_open ##1 !gate_open) else $error("auto gate not closed");
  meas_keep_a: assert property (ms_st == M_IDLE && iv_end && !gate_open
    |=> $stable(freq_r)) else $error("measured value changed");
  cmp_ge_a: assert property (!cfg_r.meas_mode && ccfg_r.cond0 == CMP_GE
    && $signed(cnt_r) >= $signed(cmp0_r) |=> o_compare_output_0)
    else $error("compare output not set");
  event_a: assert property (ovf && ccfg_r.ev_en[1] |=> o_hw_event && o_event_cause[1])
    else $error("overflow event missing");
  feedback_a: assert property (1'b1 |=> o_feedback.counter == $past(cnt_r))
    else $error("feedback counter stale");
endmodule : enc_count

// ==== tb/enc_partner.sv ====
module enc_partner (
  input wire logic i_clk,
  output logic o_a,
  output logic o_b,
  output logic o_n,
  output logic [2:0] o_di
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph = 2'h0;
  logic [1:0] nx;
  logic [3:0] rc = 4'h0;
  bit run = 0;
  bit run_up = 1;
  initial begin
    o_a = 1'b0;
    o_b = 1'b0;
    o_n = 1'b0;
    o_di = 3'h0;
  end
  // quadrature phases, a leads b when counting up
  function automatic logic [1:0] gray(input logic [1:0] p);
    return (p == 2'h0) ? 2'h0 : (p == 2'h1) ? 2'h2 : (p == 2'h2) ? 2'h3 : 2'h1;
  endfunction : gray
  task automatic home();
    ph = 2'h0;
    {o_a, o_b} <= 2'h0;
    o_n <= 1'b0;
    o_di <= 3'h0;
  endtask : home
  // edges spaced 8 cycles, above filter settle time
  task automatic quad(input int k, input bit up);
    repeat (k) begin
      repeat (8) @(posedge i_clk);
      ph = up ? ph + 2'h1 : ph - 2'h1;
      {o_a, o_b} <= gray(ph);
    end
  endtask : quad
  task automatic pulse(input int k, input bit on_b);
    repeat (k) begin
      repeat (8) @(posedge i_clk);
      if (on_b) o_b <= 1'b1; else o_a <= 1'b1;
      repeat (8) @(posedge i_clk);
      if (on_b) o_b <= 1'b0; else o_a <= 1'b0;
    end
  endtask : pulse
  task automatic set_b(input bit v);
    @(posedge i_clk);
    o_b <= v;
  endtask : set_b
  task automatic set_di(input int i, input bit v);
    @(posedge i_clk);
    o_di[i] <= v;
  endtask : set_di
  task automatic index_pulse();
    @(posedge i_clk);
    o_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_n <= 1'b0;
  endtask : index_pulse
  task automatic glitch(input int w);
    @(posedge i_clk);
    o_a <= 1'b1;
    repeat (w) @(posedge i_clk);
    o_a <= 1'b0;
  endtask : glitch
  // free running steps every 10 cycles
  always @(posedge i_clk) begin
    nx = run_up ? ph + 2'h1 : ph - 2'h1;
    if (run && rc == 4'h9) begin
      rc <= 4'h0;
      ph = nx;
      {o_a, o_b} <= gray(nx);
    end else if (run) begin
      rc <= rc + 4'h1;
    end
  end
endmodule : enc_partner

// ==== tb/encoder_counter_measure_compare_bench.sv ====
module encoder_counter_measure_compare_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import enc_count_pkg::*;
  logic i_clk, i_rst, wr_s, rd_s, a, b, n, out0, out1, hw_ev;
  logic [3:0] addr, cause;
  logic [3:0] ev_seen = 4'h0;
  logic [2:0] di;
  logic [31:0] wdata, rdata, d;
  feedback_t fb;
  cfg_t c;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] lim1 [3] = '{32'h0000_0000, 32'hFFFF_FFFB, 32'h0000_0000};
  logic [31:0] lim2 [3] = '{32'h0000_0002, 32'hFFFF_FFFD, 32'h0000_0000};

  enc_partner enc (.i_clk(i_clk), .o_a(a), .o_b(b), .o_n(n), .o_di(di));
  enc_count #(.UPD_BASE(100)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_enc_a(a), .i_enc_b(b), .i_enc_n(n),
    .i_process_input_0(di[0]), .i_process_input_1(di[1]), .i_process_input_2(di[2]),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .o_compare_output_0(out0), .o_compare_output_1(out1), .o_hw_event(hw_ev),
    .o_event_cause(cause), .o_feedback(fb));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (i_rst) ev_seen <= 4'h0;
    else if (hw_ev === 1'b1) ev_seen <= ev_seen | cause;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("mismatches %0d, checks %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask : cyc
  task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
    @(posedge i_clk);
    addr <= ad;
    wdata <= dt;
    wr_s <= 1'b1;
    @(posedge i_clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, output logic [31:0] dt);
    @(posedge i_clk);
    addr <= ad;
    rd_s <= 1'b1;
    @(posedge i_clk);
    rd_s <= 1'b0;
    #1 dt = rdata;
  endtask : rd
  task automatic reset_dut();
    @(posedge i_clk);
    enc.home();
    i_rst <= 1'b1;
    cyc(4);
    i_rst <= 1'b0;
    c = '0;
  endtask : reset_dut
  task automatic count_is(input logic [31:0] exp);
    cyc(8);
    rd(A_COUNT, d);
    chk("count", d, exp);
    chk("feedback count", fb.counter, exp);
  endtask : count_is

  task automatic t_reset();
    rd(A_HI, d);
    chk("upper limit", d, RST_HI);
    rd(A_LO, d);
    chk("lower limit", d, RST_LO);
    rd(A_IPU, d);
    chk("increments", d, RST_IPU);
    wr(A_COUNT, 32'h0000_1234);
    count_is(RST_ZERO);
  endtask : t_reset
  task automatic t_quad();
    reset_dut();
    wr(A_CMPCFG, 32'h0000_00C0);
    wr(A_CTRL, 32'h0000_0001);
    enc.quad(3, 1);
    enc.quad(3, 0);
    count_is(32'h0000_0000);
    chk("zero and reversal", {28'h0, ev_seen & 4'hC}, 32'h0000_000C);
    enc.quad(10, 1);
    count_is(32'h0000_000A);
    chk("direction up", {31'h0, fb.status[7]}, 32'h0000_0001);
  endtask : t_quad
  task automatic t_gate();
    reset_dut();
    c.hw_en = 1'b1;
    wr(A_CFG, c);
    wr(A_CTRL, 32'h0000_0001);
    enc.quad(2, 1);
    count_is(32'h0000_0000);
    enc.set_di(0, 1);
    cyc(6);
    chk("gate open", {31'h0, fb.status[6]}, 32'h0000_0001);
    enc.quad(2, 1);
    count_is(32'h0000_0002);
    wr(A_CTRL, 32'h0000_0000);
    enc.quad(2, 1);
    count_is(32'h0000_0002);
  endtask : t_gate
  task automatic t_modes();
    reset_dut();
    wr(A_CTRL, 32'h0000_0001);
    c.enc = ENC_PULSE_DIR;
    wr(A_CFG, c);
    enc.set_b(1);
    enc.pulse(3, 0);
    count_is(32'hFFFF_FFFD);
    c.enc = ENC_PULSE;
    wr(A_CFG, c);
    wr(A_CTRL, 32'h0000_0003);
    enc.pulse(2, 0);
    count_is(32'hFFFF_FFFB);
    enc.set_b(0);
    c.enc = ENC_UPDOWN;
    wr(A_CFG, c);
    wr(A_CTRL, 32'h0000_0001);
    enc.pulse(6, 0);
    enc.pulse(1, 1);
    count_is(32'h0000_0000);
  endtask : t_modes
  task automatic t_limits();
    for (int v = 0; v < 3; v++) begin
      reset_dut();
      wr(A_HI, 32'h0000_0005);
      wr(A_LO, 32'hFFFF_FFFB);
      wr(A_CMPCFG, 32'h0000_0020);
      c.reload_opp = (v == 1);
      c.limit_stop = (v == 2);
      wr(A_CFG, c);
      wr(A_CTRL, 32'h0000_0001);
      enc.quad(6, 1);
      count_is(lim1[v]);
      chk("overflow event", {31'h0, ev_seen[1]}, 32'h0000_0001);
      chk("auto stop", {31'h0, fb.status[0]}, {31'h0, c.limit_stop});
      enc.quad(2, 1);
      count_is(lim2[v]);
    end
  endtask : t_limits
  task automatic t_capsync();
    reset_dut();
    wr(A_START, 32'h0000_0003);
    c.cap_sel = CAP_RISE;
    c.cap_di = 2'h1;
    c.cap_reload = 1'b1;
    wr(A_CFG, c);
    wr(A_CTRL, 32'h0000_0001);
    enc.quad(5, 1);
    cyc(8);
    enc.set_di(1, 1);
    count_is(32'h0000_0003);
    rd(A_CAPT, d);
    chk("capture", d, 32'h0000_0005);
    chk("feedback capture", fb.capture, 32'h0000_0005);
    c.sync_sel = SYN_N;
    wr(A_CFG, c);
    enc.quad(2, 1);
    enc.index_pulse();
    count_is(32'h0000_0003);
    c.sync_sel = SYN_FALL;
    c.sync_di = 2'h2;
    wr(A_CFG, c);
    enc.set_di(2, 1);
    enc.quad(1, 1);
    count_is(32'h0000_0004);
    enc.set_di(2, 0);
    count_is(32'h0000_0003);
    c.gate_load = 1'b1;
    wr(A_CFG, c);
    enc.quad(2, 1);
    count_is(32'h0000_0005);
    wr(A_CTRL, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0001);
    count_is(32'h0000_0003);
    c.sync_sel = SYN_N_LVL;
    wr(A_CFG, c);
    enc.quad(1, 1);
    enc.index_pulse();
    count_is(32'h0000_0004);
    enc.set_di(2, 1);
    enc.index_pulse();
    count_is(32'h0000_0003);
  endtask : t_capsync
  task automatic t_compare();
    reset_dut();
    wr(A_CMP0, 32'h0000_0004);
    wr(A_CMP1, 32'h0000_0001);
    wr(A_HYST, 32'h0000_0002);
    wr(A_CMPCFG, 32'h0000_0009);
    wr(A_CTRL, 32'h0000_0001);
    cyc(4);
    chk("out0 low", {out1, out0}, 2'h2);
    wr(A_CMPCFG, 32'h0000_0019);
    enc.quad(4, 1);
    cyc(8);
    chk("out0 high", {out1, out0}, 2'h1);
    chk("compare event", {31'h0, ev_seen[0]}, 32'h0000_0001);
    enc.quad(1, 0);
    cyc(8);
    chk("held in band", {31'h0, out0}, 32'h0000_0001);
    enc.quad(2, 0);
    cyc(8);
    chk("left band", {out1, out0}, 2'h2);
  endtask : t_compare
  task automatic t_measure();
    reset_dut();
    wr(A_IPU, 32'h0000_000A);
    wr(A_CMP0, 32'h0000_1388);
    wr(A_CMPCFG, 32'h0000_0001);
    c.meas_mode = 1'b1;
    wr(A_CFG, c);
    wr(A_CTRL, 32'h0000_0001);
    enc.run <= 1;
    cyc(400);
    chk("frequency", fb.measured, 32'h461C_4000);
    rd(A_FREQ, d);
    chk("frequency reg", d, 32'h461C_4000);
    chk("measure compare", {31'h0, out0}, 32'h0000_0001);
    c.mtype = MT_VEL;
    wr(A_CFG, c);
    cyc(300);
    chk("velocity", fb.measured, 32'h447A_0000);
    c.mtype = MT_PER;
    wr(A_CFG, c);
    cyc(4);
    chk("period", fb.measured, 32'h38D1_8000);
    c.mtype = MT_FREQ;
    wr(A_CFG, c);
    enc.run_up <= 0;
    cyc(400);
    chk("negative freq", fb.measured, 32'hC61C_4000);
    wr(A_CTRL, 32'h0000_0000);
    cyc(300);
    chk("held value", fb.measured, 32'hC61C_4000);
    enc.run <= 0;
  endtask : t_measure
  task automatic t_filter();
    reset_dut();
    c.filt = 7'h05;
    wr(A_CFG, c);
    wr(A_CTRL, 32'h0000_0001);
    enc.glitch(3);
    count_is(32'h0000_0000);
    enc.quad(1, 1);
    count_is(32'h0000_0001);
  endtask : t_filter

  initial begin
    i_rst = 1'b1;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr_s = 1'b0;
    rd_s = 1'b0;
    cyc(16);
    i_rst <= 1'b0;
    t_reset();
    t_quad();
    t_gate();
    t_modes();
    t_limits();
    t_capsync();
    t_compare();
    t_measure();
    t_filter();
    complete_run();
  end
endmodule : encoder_counter_measure_compare_bench
